// ---- rtl/mrs_pkg.sv ----
// Shared constants, command encoding and helpers for mode register command spacing
package mrs_pkg;

  // Link command encoding
  typedef enum logic [2:0] {
    CMD_DES          = 3'h0,
    CMD_MRW          = 3'h1,
    CMD_MRR          = 3'h2,
    CMD_READ         = 3'h3,
    CMD_WRITE        = 3'h4,
    CMD_MASKED_WRITE = 3'h5,
    CMD_ACTIVATE     = 3'h6,
    CMD_PRECHARGE    = 3'h7
  } mrs_cmd_e;

  // Mode register file layout
  localparam int           MR_ADDR_W     = 6;
  localparam int           MR_DATA_W     = 8;
  localparam int           BANK_W        = 3;
  localparam int           NUM_BANKS     = 8;
  localparam int           MR_COUNT      = 64;
  localparam logic [5:0]   MR_BOOST_ADDR = 6'h0d;
  localparam int           MR_BOOST_BIT  = 3;
  localparam logic [5:0]   MR_ODT_ADDR   = 6'h0b;
  localparam int           MR_ODT_LSB    = 0;
  localparam int           MR_ODT_W      = 3;

  // Timing figures
  localparam int SYS_PERIOD_PS    = 4000;
  localparam int MIN_POST_PS      = 7500;
  localparam int MIN_POST_CK      = 8;
  localparam int MRW_PERIOD_PS    = 10000;
  localparam int MRW_PERIOD_CK    = 10;
  localparam int MRD_PS           = 14000;
  localparam int MRD_CK           = 10;
  localparam int BOOST_ON_PS      = 200000;
  localparam int BOOST_OFF_PS     = 100000;
  localparam int MRR_PERIOD_CK    = 8;
  localparam int MRR_TO_MRW_EXTRA = 3;
  localparam int ODT_ON_EXTRA     = 1;
  localparam int WR_EXTRA         = 1;
  localparam int MRRI_SUB_CK      = 3;

  // Spacing counter width
  localparam int GAP_W = 8;

  // Round a time up to whole clock cycles
  function automatic int mrs_ceil_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction : mrs_ceil_div

  function automatic int mrs_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : mrs_max

  // Count one link cycle down, saturating at zero
  function automatic logic [GAP_W-1:0] mrs_dec(input logic [GAP_W-1:0] cur);
    return (cur != '0) ? cur - 1'b1 : cur;
  endfunction : mrs_dec

  // Extend a wait so that a command is allowed no earlier than gap cycles on
  function automatic logic [GAP_W-1:0] mrs_hold(input logic [GAP_W-1:0] cur, input logic [GAP_W-1:0] gap);
    logic [GAP_W-1:0] want;
    want = (gap != '0) ? gap - 1'b1 : '0;
    return (want > cur) ? want : cur;
  endfunction : mrs_hold

endpackage : mrs_pkg

// ---- rtl/mrs_link_if.sv ----
// Command/address link between memory controller and DRAM end
interface mrs_link_if;
  import mrs_pkg::*;
  logic                 ck;        // Link clock, made by the controller
  mrs_cmd_e             cmd;       // Command, deselect when idle
  logic [BANK_W-1:0]    ba;        // Bank address
  logic [MR_ADDR_W-1:0] ma;        // Mode register address
  logic [MR_DATA_W-1:0] op;        // Mode register write data
  logic                 ap;        // Auto-precharge with read/write
  logic [MR_DATA_W-1:0] rd_data;   // Mode read result
  logic                 rd_toggle; // Flips once per mode read result

  modport dram (input ck, input cmd, input ba, input ma, input op, input ap,
                output rd_data, output rd_toggle);
  modport ctrl (output ck, output cmd, output ba, output ma, output op, output ap,
                input rd_data, input rd_toggle);
endinterface : mrs_link_if

// ---- rtl/mrs_dram.sv ----
// DRAM end: bank state, mode registers, boost mode and mode read return
module mrs_dram
  import mrs_pkg::*;
#(
  parameter int RL = 14
) (
  mrs_link_if.dram   lnk,
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  ce,
  output logic       boost_on,
  output logic       any_bank_active
);

  typedef enum logic [0:0] {
    DV_IDLE = 1'b0,
    DV_WAIT = 1'b1
  } mrs_rd_e;

  localparam logic [GAP_W-1:0] RD_WAIT = GAP_W'(RL - 1);

  // Link-domain state
  typedef struct packed {
    logic [1:0]                         ce_s;
    logic [MR_COUNT-1:0][MR_DATA_W-1:0] mr;
    logic [NUM_BANKS-1:0]               bank_active;
    mrs_rd_e                            rd_state;
    logic [GAP_W-1:0]                   rd_cnt;
    logic [MR_DATA_W-1:0]               rd_hold;
    logic [MR_DATA_W-1:0]               rd_data;
    logic                               rd_toggle;
  } mrs_dlink_s;

  // System-domain state
  typedef struct packed {
    logic [1:0] boost_s;
    logic [1:0] active_s;
  } mrs_dsys_s;

  mrs_dlink_s ls, next_ls;
  mrs_dsys_s  ss, next_ss;
  logic [1:0] rst_s;

  // Reset reaches the link side at once and leaves it on the link clock.
  // The controller holds the link clock still during reset, so a plain
  // two-flop synchroniser would never see reset at all.
  always_ff @(posedge lnk.ck or posedge rst) begin
    if (rst) begin
      rst_s <= 2'h3;
    end else begin
      rst_s <= {rst_s[0], 1'b0};
    end
  end

  // Command decode on the link clock
  always_comb begin
    next_ls       = ls;
    next_ls.ce_s  = {ls.ce_s[0], ce};
    if (rst_s[1]) begin
      next_ls.mr          = '0;
      next_ls.bank_active = '0;
      next_ls.rd_state    = DV_IDLE;
      next_ls.rd_cnt      = '0;
      next_ls.rd_hold     = '0;
      next_ls.rd_data     = '0;
      next_ls.rd_toggle   = 1'b0;
    end else if (ls.ce_s[1]) begin
      // Mode read result returns after the read latency
      case (ls.rd_state)
        DV_WAIT: begin
          if (ls.rd_cnt == '0) begin
            next_ls.rd_data   = ls.rd_hold;
            next_ls.rd_toggle = ~ls.rd_toggle;
            next_ls.rd_state  = DV_IDLE;
          end else begin
            next_ls.rd_cnt = ls.rd_cnt - 1'b1;
          end
        end
        default: begin
        end
      endcase
      case (lnk.cmd)
        CMD_ACTIVATE: begin
          next_ls.bank_active[lnk.ba] = 1'b1;
        end
        CMD_PRECHARGE: begin
          next_ls.bank_active[lnk.ba] = 1'b0;
        end
        CMD_MRW: begin
          // Taken in any bank state, bank state kept
          // Boost bit and vref fields are stored whatever boost is
          next_ls.mr[lnk.ma] = lnk.op;
        end
        CMD_MRR: begin
          next_ls.rd_hold  = ls.mr[lnk.ma]; // Bank state kept
          next_ls.rd_cnt   = RD_WAIT;
          next_ls.rd_state = DV_WAIT;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge lnk.ck) begin
    ls <= next_ls;
  end

  // Status bits cross into the system clock
  always_comb begin
    next_ss = ss;
    if (ce) begin
      next_ss.boost_s  = {ss.boost_s[0], ls.mr[MR_BOOST_ADDR][MR_BOOST_BIT]};
      next_ss.active_s = {ss.active_s[0], |ls.bank_active};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ss <= '0;
    end else begin
      ss <= next_ss;
    end
  end

  assign lnk.rd_data     = ls.rd_data;
  assign lnk.rd_toggle   = ls.rd_toggle;
  assign boost_on        = ss.boost_s[1];
  assign any_bank_active = ss.active_s[1];

endmodule : mrs_dram

// ---- rtl/mrs_ctrl.sv ----
// Controller end: link clock divider, command spacing and mode read capture
module mrs_ctrl
  import mrs_pkg::*;
#(
  parameter int DIV      = 1,
  parameter int RL       = 14,
  parameter int WL       = 8,
  parameter int BL       = 16,
  parameter int DQSCK_CK = 2,
  parameter int WPRE_CK  = 2,
  parameter int RPST_CK  = 0,
  parameter int TERMINATION_ON_LATENCY   = 4,
  parameter int ODTON_CK = 1,
  parameter int WRITE_RECOVERY_COUNT      = 6,
  parameter int WTR_CK   = 4,
  parameter int RCD_CK   = 8,
  parameter int XP_CK    = 3
) (
  mrs_link_if.ctrl              lnk,
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire mrs_cmd_e         req_cmd,
  input  wire logic [BANK_W-1:0]    req_bank,
  input  wire logic [MR_ADDR_W-1:0] req_addr,
  input  wire logic [MR_DATA_W-1:0] req_data,
  input  wire logic             req_ap,
  input  wire logic             pd_exit,
  output logic                  rsp_valid,
  output logic [MR_DATA_W-1:0]  rsp_data,
  output logic                  odt_on,
  output logic                  boost_on
);

  localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

  // Link clock period and derived cycle counts
  localparam int CK_PS   = SYS_PERIOD_PS * 2 * DIV;
  localparam int POST_CK = mrs_max(mrs_ceil_div(MIN_POST_PS, CK_PS), MIN_POST_CK);

  localparam logic [GAP_W-1:0] G_MRR_MRR  = GAP_W'(MRR_PERIOD_CK);
  localparam logic [GAP_W-1:0] G_MRR_WOFF = GAP_W'(RL + DQSCK_CK + BL / 2 - WL + WPRE_CK + RPST_CK);
  localparam logic [GAP_W-1:0] G_MRR_WON  = GAP_W'(RL + DQSCK_CK + BL / 2 - TERMINATION_ON_LATENCY - ODTON_CK + RPST_CK
                                                   + ODT_ON_EXTRA);
  localparam logic [GAP_W-1:0] G_MRR_MRW  = GAP_W'(RL + DQSCK_CK + BL / 2 + MRR_TO_MRW_EXTRA);
  localparam logic [GAP_W-1:0] G_RD_MRR   = GAP_W'(BL / 2);
  localparam logic [GAP_W-1:0] G_RD_MRW   = GAP_W'(RL + BL / 2 + DQSCK_CK + RPST_CK + POST_CK);
  localparam logic [GAP_W-1:0] G_WR_MRR   = GAP_W'(WL + BL / 2 + WR_EXTRA + WTR_CK);
  localparam logic [GAP_W-1:0] G_WR_MRW   = GAP_W'(WL + WR_EXTRA + BL / 2 + POST_CK);
  localparam logic [GAP_W-1:0] G_WRA_MRW  = GAP_W'(WL + WR_EXTRA + BL / 2 + POST_CK + WRITE_RECOVERY_COUNT);
  localparam logic [GAP_W-1:0] G_MRW_RW   = GAP_W'(mrs_max(mrs_ceil_div(MRD_PS, CK_PS), MRD_CK));
  localparam logic [GAP_W-1:0] G_MRW_MRW  = GAP_W'(mrs_max(mrs_ceil_div(MRW_PERIOD_PS, CK_PS), MRW_PERIOD_CK));
  localparam logic [GAP_W-1:0] G_BOOST_ON = GAP_W'(mrs_ceil_div(BOOST_ON_PS, CK_PS));
  localparam logic [GAP_W-1:0] G_BOOST_OF = GAP_W'(mrs_ceil_div(BOOST_OFF_PS, CK_PS));
  localparam logic [GAP_W-1:0] G_PD_MRR   = GAP_W'(XP_CK + RCD_CK - MRRI_SUB_CK);

  // Whole controller state
  typedef struct packed {
    logic [DIV_W-1:0]     div_cnt;
    logic                 ck;
    mrs_cmd_e             cmd;
    logic [BANK_W-1:0]    ba;
    logic [MR_ADDR_W-1:0] ma;
    logic [MR_DATA_W-1:0] op;
    logic                 ap;
    logic [GAP_W-1:0]     w_mrr;
    logic [GAP_W-1:0]     w_rd;
    logic [GAP_W-1:0]     w_wr;
    logic [GAP_W-1:0]     w_mrw;
    logic [GAP_W-1:0]     w_any;
    logic                 odt_on;
    logic                 boost_on;
    logic [2:0]           rt_s;
    logic [MR_DATA_W-1:0] rsp_data;
    logic                 rsp_valid;
  } mrs_ctrl_s;

  mrs_ctrl_s st, next_st;
  logic      tick;
  logic      may_issue;

  // A request may go only once every wait that applies to it has run out
  always_comb begin
    may_issue = 1'b0;
    if (st.w_any == '0) begin // Deselect-only windows
      case (req_cmd)
        CMD_MRR:          may_issue = (st.w_mrr == '0);
        CMD_READ:         may_issue = (st.w_rd == '0);
        CMD_WRITE:        may_issue = (st.w_wr == '0);
        CMD_MASKED_WRITE: may_issue = (st.w_wr == '0);
        CMD_MRW:          may_issue = (st.w_mrw == '0);
        CMD_ACTIVATE:     may_issue = 1'b1;
        CMD_PRECHARGE:    may_issue = 1'b1;
        default:          may_issue = 1'b0;
      endcase
    end
  end

  // Divider, issue and spacing bookkeeping
  always_comb begin
    next_st   = st;
    tick      = 1'b0;
    req_ready = 1'b0;
    if (ce) begin
      // Mode read result crosses as a toggle
      next_st.rsp_valid = 1'b0;
      next_st.rt_s      = {st.rt_s[1:0], lnk.rd_toggle};
      if (st.rt_s[2] != st.rt_s[1]) begin
        next_st.rsp_valid = 1'b1;
        next_st.rsp_data  = lnk.rd_data;
      end
      // Link clock divider; commands change on the falling edge
      if (st.div_cnt == DIV_LAST) begin
        next_st.div_cnt = '0;
        next_st.ck      = ~st.ck;
        tick            = st.ck;
      end else begin
        next_st.div_cnt = st.div_cnt + 1'b1;
      end
      if (tick) begin
        next_st.w_mrr = mrs_dec(st.w_mrr);
        next_st.w_rd  = mrs_dec(st.w_rd);
        next_st.w_wr  = mrs_dec(st.w_wr);
        next_st.w_mrw = mrs_dec(st.w_mrw);
        next_st.w_any = mrs_dec(st.w_any);
        next_st.cmd   = CMD_DES;
        if (req_valid && may_issue) begin
          req_ready  = 1'b1;
          next_st.cmd = req_cmd;
          next_st.ba  = req_bank;
          next_st.ma  = req_addr;
          next_st.op  = req_data;
          next_st.ap  = req_ap;
          case (req_cmd)
            CMD_MRR: begin
              next_st.w_mrr = mrs_hold(next_st.w_mrr, G_MRR_MRR);
              next_st.w_rd  = mrs_hold(next_st.w_rd, G_MRR_MRR);
              next_st.w_any = mrs_hold(next_st.w_any, G_MRR_MRR);
              next_st.w_mrw = mrs_hold(next_st.w_mrw, G_MRR_MRW);
              if (st.odt_on) begin
                next_st.w_wr = mrs_hold(next_st.w_wr, G_MRR_WON);
              end else begin
                next_st.w_wr = mrs_hold(next_st.w_wr, G_MRR_WOFF);
              end
            end
            CMD_READ: begin
              next_st.w_mrr = mrs_hold(next_st.w_mrr, G_RD_MRR);
              next_st.w_mrw = mrs_hold(next_st.w_mrw, G_RD_MRW);
            end
            CMD_WRITE, CMD_MASKED_WRITE: begin
              next_st.w_mrr = mrs_hold(next_st.w_mrr, G_WR_MRR);
              if (req_ap) begin
                next_st.w_mrw = mrs_hold(next_st.w_mrw, G_WRA_MRW);
              end else begin
                next_st.w_mrw = mrs_hold(next_st.w_mrw, G_WR_MRW);
              end
            end
            CMD_MRW: begin
              next_st.w_rd  = mrs_hold(next_st.w_rd, G_MRW_RW);
              next_st.w_wr  = mrs_hold(next_st.w_wr, G_MRW_RW);
              next_st.w_mrw = mrs_hold(next_st.w_mrw, G_MRW_MRW);
              if (req_addr == MR_BOOST_ADDR) begin
                next_st.boost_on = req_data[MR_BOOST_BIT];
                if (req_data[MR_BOOST_BIT]) begin
                  next_st.w_any = mrs_hold(next_st.w_any, G_BOOST_ON);
                end else begin
                  next_st.w_any = mrs_hold(next_st.w_any, G_BOOST_OF);
                end
              end
              if (req_addr == MR_ODT_ADDR) begin
                next_st.odt_on = |req_data[MR_ODT_LSB +: MR_ODT_W];
              end
            end
            default: begin
            end
          endcase
        end
      end
      // Power-down exit holds off the next mode read
      if (pd_exit) begin
        next_st.w_mrr = mrs_hold(next_st.w_mrr, G_PD_MRR);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Link and user outputs straight from state
  assign lnk.ck    = st.ck;
  assign lnk.cmd   = st.cmd;
  assign lnk.ba    = st.ba;
  assign lnk.ma    = st.ma;
  assign lnk.op    = st.op;
  assign lnk.ap    = st.ap;
  assign rsp_valid = st.rsp_valid;
  assign rsp_data  = st.rsp_data;
  assign odt_on    = st.odt_on;
  assign boost_on  = st.boost_on;

endmodule : mrs_ctrl

// ---- dv/mrs_asserts.sv ----
// Link-side checks of command spacing, boost windows and mode read return
module mrs_asserts
  import mrs_pkg::*;
#(
  parameter int RL = 14
) (
  input wire logic                 ck,
  input wire logic                 rst,
  input wire mrs_cmd_e             cmd,
  input wire logic [MR_ADDR_W-1:0] ma,
  input wire logic [MR_DATA_W-1:0] op,
  input wire logic                 ap,
  input wire logic                 rd_toggle
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gaps in link cycles for the default timing figures
  localparam int G_MRR_MRW = RL + 13;
  localparam int G_OFF     = RL + 4;
  localparam int G_ON      = RL + 6;
  localparam int G_RD_MRW  = RL + 18;
  localparam int G_BON     = (BOOST_ON_PS + 7999) / 8000;
  localparam int G_BOFF    = (BOOST_OFF_PS + 7999) / 8000;
  localparam int RT_LO     = RL;
  localparam int RT_HI     = RL + 2;

  logic [7:0] s_mrr, s_rd, s_wr, s_mrw, s_bst, g_bst;
  logic       wr_ap, odt, is_wr;

  assign is_wr = cmd inside {CMD_WRITE, CMD_MASKED_WRITE};

  function automatic logic [7:0] sat(input logic [7:0] v);
    return v + {7'h0, v != 8'hff};
  endfunction : sat

  // Link cycles since each command class, saturating
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      {s_mrr, s_rd, s_wr, s_mrw, s_bst} <= '1;
      {g_bst, wr_ap, odt} <= '0;
    end else begin
      s_mrr <= (cmd == CMD_MRR) ? 8'h01 : sat(s_mrr);
      s_rd  <= (cmd == CMD_READ) ? 8'h01 : sat(s_rd);
      s_wr  <= is_wr ? 8'h01 : sat(s_wr);
      s_mrw <= (cmd == CMD_MRW) ? 8'h01 : sat(s_mrw);
      s_bst <= (cmd == CMD_MRW && ma == MR_BOOST_ADDR) ? 8'h01 : sat(s_bst);
      if (is_wr) wr_ap <= ap;
      if (cmd == CMD_MRW && ma == MR_BOOST_ADDR) g_bst <= op[MR_BOOST_BIT] ? 8'(G_BON) : 8'(G_BOFF);
      if (cmd == CMD_MRW && ma == MR_ODT_ADDR) odt <= |op[MR_ODT_LSB +: MR_ODT_W];
    end
  end

  default clocking cb @(posedge ck); endclocking
  default disable iff (rst);

  sequence mrr_issued;
    cmd == CMD_MRR;
  endsequence
  sequence answer_flip;
    ##[RT_LO:RT_HI] $changed(rd_toggle);
  endsequence

  a_mrr_quiet_period: assert property (cmd == CMD_MRR |=> cmd == CMD_DES [*7])
    else $error("command inside mode read period");
  a_mrr_answer_back: assert property (mrr_issued |-> answer_flip)
    else $error("mode read result missing");
  a_mrr_to_mrw: assert property (cmd == CMD_MRW |-> s_mrr >= G_MRR_MRW)
    else $error("mode write too soon after mode read");
  a_mrr_to_write: assert property (is_wr |-> s_mrr >= (odt ? G_ON : G_OFF))
    else $error("write too soon after mode read");
  a_rw_to_mrr: assert property (cmd == CMD_MRR |-> s_rd >= 8 && s_wr >= 21)
    else $error("mode read too soon after read or write");
  a_rw_to_mrw: assert property (cmd == CMD_MRW |-> s_rd >= G_RD_MRW && s_wr >= (wr_ap ? 31 : 25))
    else $error("mode write too soon after read or write");
  a_mrw_set_delay: assert property (cmd inside {CMD_MRW, CMD_READ, CMD_WRITE, CMD_MASKED_WRITE} |-> s_mrw >= 10)
    else $error("command too soon after mode write");
  a_boost_window: assert property (cmd != CMD_DES |-> s_bst >= g_bst)
    else $error("command inside boost settle window");
endmodule : mrs_asserts

// ---- dv/mode_reg_cmd_spacing_vref_current_boost_tb.sv ----
// Bench joining controller and DRAM ends across the link
module mode_reg_cmd_spacing_vref_current_boost_tb
  import mrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RL = 14;

  logic              sys_clk   = 1'b0;
  logic              rst       = 1'b0;
  logic              req_valid = 1'b0;
  mrs_cmd_e          req_cmd   = CMD_DES;
  logic [BANK_W-1:0] req_bank  = '0;
  logic [5:0]        req_addr  = '0;
  logic [7:0]        req_data  = '0;
  logic              req_ap    = 1'b0;
  logic              pd_exit   = 1'b0;
  logic              req_ready, rsp_valid, odt_on, c_boost, d_boost, bank_act;
  logic [7:0]        rsp_data, d;
  logic [5:0]        a;
  logic [7:0]        mr [64];
  int                err_count = 0, comparisons = 0, cyc = 0, seed = 32'h7001, w = 0;

  mrs_link_if lnk ();
  mrs_ctrl #(.RL(RL)) mrs_ctrl_inst (.lnk(lnk), .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_data(req_data),
    .req_ap(req_ap), .pd_exit(pd_exit), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .odt_on(odt_on),
    .boost_on(c_boost));
  mrs_dram #(.RL(RL)) mrs_dram_inst (.lnk(lnk), .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .boost_on(d_boost),
    .any_bank_active(bank_act));
  mrs_asserts #(.RL(RL)) mrs_asserts_inst (.ck(lnk.ck), .rst(rst), .cmd(lnk.cmd), .ma(lnk.ma), .op(lnk.op),
    .ap(lnk.ap), .rd_toggle(lnk.rd_toggle));

  // System clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Boost window in sys cycles, less slack for the request handshake
  function automatic int boost_gap(input logic on);
    return 2 * (((on ? BOOST_ON_PS : BOOST_OFF_PS) + 7999) / (2 * SYS_PERIOD_PS)) - 4;
  endfunction : boost_gap

  // Hold one request until accepted; w counts cycles waited, the accepting one included
  task automatic issue(input mrs_cmd_e c, input logic [5:0] ad, input logic [7:0] dt, input logic p);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_bank  <= ad[2:0];
    req_addr  <= ad;
    req_data  <= dt;
    req_ap    <= p;
    w = 0;
    do begin
      @(negedge sys_clk);
      w++;
    end while (req_ready !== 1'b1 && w < 3000);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    if (c == CMD_MRW) mr[ad] = dt;
    if (w >= 3000) err_count++;
  endtask : issue

  // Mode read, wait for the byte and compare with the shadow copy
  task automatic mrr_check(input logic [5:0] ad);
    int n;
    issue(CMD_MRR, ad, 8'h00, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) err_count++;
    check(rsp_data, mr[ad]);
  endtask : mrr_check

  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask : settle

  // Main sequence
  initial begin
    rst <= 1'b1; // A real rising edge arms the asynchronous reset paths
    foreach (mr[i]) mr[i] = 8'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (20) @(posedge sys_clk);
    issue(CMD_MRW, MR_BOOST_ADDR, 8'h08, 1'b0);
    issue(CMD_MRW, 6'h0c, 8'h5a, 1'b0);
    check({7'h0, w >= boost_gap(1'b1)}, 8'h01);
    settle();
    check({6'h0, c_boost, d_boost}, 8'h03);
    mrr_check(6'h0c);
    issue(CMD_MRW, MR_BOOST_ADDR, 8'h00, 1'b0);
    issue(CMD_ACTIVATE, 6'h03, 8'h00, 1'b0);
    check({7'h0, w >= boost_gap(1'b0)}, 8'h01);
    settle();
    check({6'h0, c_boost, d_boost}, 8'h00);
    $display("boost test done");
    check({7'h0, bank_act}, 8'h01);
    issue(CMD_MRW, 6'h11, 8'ha5, 1'b0);
    mrr_check(6'h11);
    settle();
    check({7'h0, bank_act}, 8'h01);
    issue(CMD_PRECHARGE, 6'h03, 8'h00, 1'b0);
    settle();
    check({7'h0, bank_act}, 8'h00);
    $display("bank state test done");
    for (int k = 0; k < 2; k++) begin
      issue(CMD_MRW, MR_ODT_ADDR, k ? 8'h04 : 8'h00, 1'b0);
      mrr_check(MR_ODT_ADDR);
      check({7'h0, odt_on}, {7'h0, k[0]});
      issue(CMD_WRITE, 6'h01, 8'h00, 1'b1);
      issue(CMD_MRW, 6'h01, 8'h00, 1'b0);
    end
    $display("termination test done");
    pd_exit <= 1'b1;
    @(posedge sys_clk);
    pd_exit <= 1'b0;
    mrr_check(6'h01);
    check({7'h0, w >= 12}, 8'h01);
    $display("power-down exit test done");
    repeat (60) begin
      a = 6'($random(seed));
      d = 8'($random(seed));
      if (a == MR_BOOST_ADDR) a = 6'h0e;
      case (2'($random(seed)))
        2'h0: issue(CMD_MRW, a, d, 1'b0);
        2'h1: mrr_check(a);
        2'h2: issue(CMD_READ, a, d, d[0]);
        default: issue(d[1] ? CMD_WRITE : CMD_MASKED_WRITE, a, d, d[0]);
      endcase
    end
    $display("random traffic test done");
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (mr[i]) mr[i] = 8'h00;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check({6'h0, c_boost, odt_on}, 8'h00);
    check({7'h0, bank_act}, 8'h00);
    mrr_check(6'h0c);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : mode_reg_cmd_spacing_vref_current_boost_tb
